//--- logic/lcd_timing_select.sv
// master/slave display timing selector with master-side timing generator
// assumes all pin inputs are asynchronous; blank_req_i and static_on_i come from clk_i logic
//
// Overview of operation
// - mode select high master, low slave
// - master enables oscillator, supply; slave disables, tristates
// - line clock pin output in master, input otherwise
// - ac polarity pin output in master, input otherwise
// - blanking pin output in master, input otherwise
module lcd_timing_select #(
    parameter int LINE_HALF = lcd_timing_pkg::LINE_HALF_CYC,
    parameter int LINES     = lcd_timing_pkg::LINES_PER_FRAME
) (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic master_select_i,
    input  wire logic blank_req_i,
    input  wire logic static_on_i,
    input  wire logic display_line_clock_pin_i,
    output logic      display_line_clock_pin_o,
    output logic      display_line_clock_pin_oe_o,
    input  wire logic lcd_ac_polarity_pin_i,
    output logic      lcd_ac_polarity_pin_o,
    output logic      lcd_ac_polarity_pin_oe_o,
    input  wire logic display_blank_control_pin_i,
    output logic      display_blank_control_pin_o,
    output logic      display_blank_control_pin_oe_o,
    output logic      common_scan_start_pin_o,
    output logic      common_scan_start_pin_oe_o,
    output logic      static_drive_pin_o,
    output logic      static_drive_pin_oe_o,
    output logic      osc_enable_o,
    output logic      power_enable_o,
    output logic      master_mode_o,
    output logic      line_tick_o,
    output logic      ac_polarity_o,
    output logic      blank_o
);

    localparam int HW     = $clog2(LINE_HALF + 1);
    localparam int LW     = $clog2(LINES + 1);
    localparam int LH_M1  = LINE_HALF - 1;

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    function automatic logic cnt_at_last(input logic [15:0] cnt, input int lim);
        cnt_at_last = (cnt == 16'(lim - 1));
    endfunction : cnt_at_last

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [lcd_timing_pkg::SYNC_WIDTH-1:0] pins_s;

    pin_sync #(
        .WIDTH (lcd_timing_pkg::SYNC_WIDTH)
    ) u_pin_sync (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .d_i    ({display_blank_control_pin_i, lcd_ac_polarity_pin_i,
                  display_line_clock_pin_i, master_select_i}),
        .q_o    (pins_s)
    );

    wire mode_s  = pins_s[lcd_timing_pkg::SYNC_MODE_BIT];
    wire line_s  = pins_s[lcd_timing_pkg::SYNC_LINE_BIT];
    wire pol_s   = pins_s[lcd_timing_pkg::SYNC_POL_BIT];
    wire blank_s = pins_s[lcd_timing_pkg::SYNC_BLANK_BIT];

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic          mode_reg;
    logic [HW-1:0] half_cnt_reg;
    logic [HW-1:0] half_cnt_next;
    logic [LW-1:0] line_cnt_reg;
    logic [LW-1:0] line_cnt_next;
    logic          gen_clk_reg;
    logic          gen_pol_reg;
    logic          line_prev_reg;
    logic          tick_reg;
    logic          pol_reg;
    logic          blank_reg;
    logic          blank_pin_reg;
    logic          scan_reg;
    logic          static_reg;

    // ----------------------------------------------------------------
    // master timing generator, held in reset while slave
    // ----------------------------------------------------------------
    wire half_end   = mode_reg && cnt_at_last(16'(half_cnt_reg), LINE_HALF);
    wire gen_rise   = half_end && !gen_clk_reg;
    wire frame_end  = gen_rise && cnt_at_last(16'(line_cnt_reg), LINES);
    wire line_rise  = line_s && !line_prev_reg;

    assign half_cnt_next = (!mode_reg || half_end) ? '0 : HW'(half_cnt_reg + 1'b1);
    assign line_cnt_next = !mode_reg ? '0 : frame_end ? '0 :
                           gen_rise ? LW'(line_cnt_reg + 1'b1) : line_cnt_reg;

    // internal timing: tick and polarity generated and blanking from blank_req_i in master, all taken from pins in slave
    wire tick_next  = mode_reg ? gen_rise : line_rise;
    wire pol_next   = mode_reg ? gen_pol_reg : pol_s;
    wire blank_next = mode_reg ? blank_req_i : blank_s;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode_reg <= lcd_timing_pkg::MODE_RESET;
        end else begin
            mode_reg <= mode_s;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            half_cnt_reg <= '0;
            line_cnt_reg <= '0;
            gen_clk_reg  <= 1'b0;
            gen_pol_reg  <= 1'b0;
        end else begin
            half_cnt_reg <= half_cnt_next;
            line_cnt_reg <= line_cnt_next;
            gen_clk_reg  <= mode_reg && (gen_clk_reg ^ half_end);
            gen_pol_reg  <= mode_reg && (gen_pol_reg ^ frame_end);
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            line_prev_reg <= 1'b0;
            tick_reg      <= 1'b0;
            pol_reg       <= 1'b0;
            blank_reg     <= 1'b0;
        end else begin
            line_prev_reg <= line_s;
            tick_reg      <= tick_next;
            pol_reg       <= pol_next;
            blank_reg     <= blank_next;
        end
    end

    // pin drive values, held low while slave; the enables decide whether they reach the wire
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            blank_pin_reg <= 1'b0;
            scan_reg      <= 1'b0;
            static_reg    <= 1'b0;
        end else begin
            blank_pin_reg <= mode_reg && blank_req_i;
            scan_reg      <= mode_reg && (line_cnt_reg == '0);
            static_reg    <= mode_reg && (gen_pol_reg ^ static_on_i);
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign display_line_clock_pin_o       = gen_clk_reg;
    assign display_line_clock_pin_oe_o    = mode_reg;
    assign lcd_ac_polarity_pin_o          = gen_pol_reg;
    assign lcd_ac_polarity_pin_oe_o       = mode_reg;
    assign display_blank_control_pin_o    = blank_pin_reg;
    assign display_blank_control_pin_oe_o = mode_reg;
    assign common_scan_start_pin_o        = scan_reg;
    assign common_scan_start_pin_oe_o     = mode_reg;
    assign static_drive_pin_o             = static_reg;
    assign static_drive_pin_oe_o          = mode_reg;
    assign osc_enable_o                   = mode_reg;
    assign power_enable_o                 = mode_reg;
    assign master_mode_o                  = mode_reg;
    assign line_tick_o                    = tick_reg;
    assign ac_polarity_o                  = pol_reg;
    assign blank_o                        = blank_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    sequence steady_master;
        master_mode_o [*2];
    endsequence

    sequence steady_slave;
        !master_mode_o [*2];
    endsequence

    chk_mode_follows_pin: assert property (
        $changed(mode_s) |=> (master_mode_o == $past(mode_s))
    ) else $error("mode did not follow synchronised select");

    chk_slave_all_off: assert property (
        !master_mode_o |-> !(osc_enable_o || power_enable_o || common_scan_start_pin_oe_o
                             || static_drive_pin_oe_o || display_line_clock_pin_oe_o)
    ) else $error("slave mode left a supply or pin enabled");

    chk_master_all_on: assert property (
        $rose(master_mode_o) |-> (osc_enable_o && power_enable_o && static_drive_pin_oe_o
                                  && common_scan_start_pin_oe_o && lcd_ac_polarity_pin_oe_o)
    ) else $error("master mode missing an enable");

    // a legal drop to slave may cut the high phase short, so it abandons the check
    chk_line_clk_half: assert property (
        disable iff (!rstn_i || !master_mode_o)
        ($rose(display_line_clock_pin_o) && master_mode_o) |->
            (display_line_clock_pin_o throughout (##LH_M1 1'b1)) ##1
            !display_line_clock_pin_o
    ) else $error("line clock high phase length wrong");

    chk_line_clk_idle: assert property (
        steady_slave |-> !display_line_clock_pin_o && !display_line_clock_pin_oe_o
    ) else $error("line clock active in slave mode");

    chk_slave_polarity: assert property (
        steady_slave |=> (ac_polarity_o == $past(pol_s))
    ) else $error("slave polarity not taken from pin");

    chk_blank_source: assert property (
        steady_master |=> (blank_o == $past(blank_req_i))
                          && (display_blank_control_pin_o == $past(blank_req_i))
    ) else $error("master blanking not driven from request");

    chk_slave_tick_src: assert property (
        (steady_slave ##0 line_tick_o) |-> $past(line_s) && !$past(line_prev_reg)
    ) else $error("slave tick without received clock edge");

endmodule : lcd_timing_select

//--- pkg/lcd_timing_pkg.sv
// constants for the master/slave display timing selector
// assumes a 20 mhz system clock and a line clock in the few-mhz range
package lcd_timing_pkg;

    localparam int   CLK_PERIOD_NS      = 50;
    localparam int   LINE_CLK_PERIOD_NS = 400;
    // half a line clock period, rounded down, never below one cycle
    localparam int   LINE_HALF_CYC      = (LINE_CLK_PERIOD_NS / 2 / CLK_PERIOD_NS) < 1 ? 1 :
                                          (LINE_CLK_PERIOD_NS / 2 / CLK_PERIOD_NS);
    localparam int   LINES_PER_FRAME    = 64;
    localparam int   SYNC_WIDTH         = 4;
    localparam int   SYNC_MODE_BIT      = 0;
    localparam int   SYNC_LINE_BIT      = 1;
    localparam int   SYNC_POL_BIT       = 2;
    localparam int   SYNC_BLANK_BIT     = 3;
    // slave after reset so that no shared pin is driven before the strap is seen
    localparam logic MODE_RESET         = 1'b0;

endpackage : lcd_timing_pkg

//--- logic/pin_sync.sv
// two-stage synchroniser for a group of independent pin levels
// assumes each bit is a level; bits are not coherent with each other
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= d_i;
            sync_reg <= meta_reg;
        end
    end

    assign q_o = sync_reg;

endmodule : pin_sync

//--- testbench/lcd_far_master.sv
// far-side master model for the shared line clock, polarity and blanking wires
// assumes bit 0 line clock, bit 1 polarity, bit 2 blanking on every vector
module lcd_far_master (
    input  wire logic       en_i,
    input  wire logic       pol_i,
    input  wire logic       blank_i,
    input  wire logic [2:0] dut_o_i,
    input  wire logic [2:0] dut_oe_i,
    output logic      [2:0] wire_o,
    output int              rises_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       line_reg = 1'b0;
    logic [2:0] mine;
    // 400 ns period, phase unrelated to clk_i; stands still while not mastering
    initial begin
        #7;
        forever #200 line_reg = en_i ? ~line_reg : 1'b0;
    end
    int         rise_cnt = 0;
    always @(posedge line_reg) rise_cnt++;
    assign rises_o = rise_cnt;
    assign mine = {blank_i, pol_i, line_reg};
    // an undriven wire shows the far master's level while en_i is high, otherwise the inverse of the dut value
    assign wire_o = (dut_oe_i & dut_o_i) | (~dut_oe_i & (en_i ? mine : ~dut_o_i));
endmodule : lcd_far_master

//--- testbench/lcd_timing_select_test.sv
// random self-checking bench for the master/slave timing selector
// assumes the far-side model forms the shared wire levels
module lcd_timing_select_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LN = 4;
    localparam int HF = lcd_timing_pkg::LINE_HALF_CYC;
    logic        clk_i, rstn_i, sel, breq, son, en, ppol, pblank;
    logic        scan_o, scan_oe, stat_o, stat_oe, osc, pwr, mm, tick, acp, blk;
    wire  [2:0]  po, poe, pw;
    int          errors, comparisons, rises;
    logic [31:0] lfsr = 32'hf9335433;

    lcd_timing_select #(.LINES(LN)) uut (
        .clk_i(clk_i), .rstn_i(rstn_i), .master_select_i(sel), .blank_req_i(breq), .static_on_i(son),
        .display_line_clock_pin_i(pw[0]), .display_line_clock_pin_o(po[0]), .display_line_clock_pin_oe_o(poe[0]),
        .lcd_ac_polarity_pin_i(pw[1]), .lcd_ac_polarity_pin_o(po[1]), .lcd_ac_polarity_pin_oe_o(poe[1]),
        .display_blank_control_pin_i(pw[2]), .display_blank_control_pin_o(po[2]),
        .display_blank_control_pin_oe_o(poe[2]), .common_scan_start_pin_o(scan_o),
        .common_scan_start_pin_oe_o(scan_oe), .static_drive_pin_o(stat_o), .static_drive_pin_oe_o(stat_oe),
        .osc_enable_o(osc), .power_enable_o(pwr), .master_mode_o(mm), .line_tick_o(tick),
        .ac_polarity_o(acp), .blank_o(blk));
    lcd_far_master far (.en_i(en), .pol_i(ppol), .blank_i(pblank), .dut_o_i(po), .dut_oe_i(poe),
        .wire_o(pw), .rises_o(rises));

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : next_rand
    function automatic logic [7:0] view(input logic m);
        return {8{m}};
    endfunction : view
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0d ns: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic set_mode(input logic m);
        @(posedge clk_i);
        sel <= m;
        en <= ~m;
        repeat (3) @(negedge clk_i);
        check({mm, osc, pwr, poe, scan_oe, stat_oe}, view(~m));
        @(negedge clk_i);
        check({mm, osc, pwr, poe, scan_oe, stat_oe}, view(m));
        $display("mode %0d test done", m);
    endtask : set_mode
    task automatic master_run();
        int   lr, lp, nr, nt, li;
        logic pl, pp, pb, ps;
        lr = -1;
        lp = -1;
        nr = 0;
        nt = 0;
        li = 0;
        pl = po[0];
        pp = po[1];
        for (int t = 0; t < 400; t++) begin
            lfsr = next_rand(lfsr);
            @(posedge clk_i);
            pb = breq;
            ps = son;
            breq <= lfsr[0];
            son <= lfsr[1];
            @(negedge clk_i);
            check({po[2], blk}, {pb, pb});
            check({acp, stat_o, scan_o}, {pp, pp ^ ps, li == 0});
            check(tick, po[0] && !pl);
            if (po[0] && !pl) begin
                if (lr >= 0) check(t - lr, 2 * HF);
                lr = t;
                nr++;
                li = (li + 1) % LN;
            end
            if (po[1] !== pp) begin
                if (lp >= 0) check(nr - lp, LN);
                lp = nr;
            end
            nt += tick;
            pl = po[0];
            pp = po[1];
        end
        check(nt, nr);
        $display("master timing test done");
    endtask : master_run
    task automatic slave_run();
        int r0, nt;
        nt = 0;
        r0 = rises;
        for (int t = 0; t < 40; t++) begin
            lfsr = next_rand(lfsr);
            @(posedge clk_i);
            ppol <= lfsr[0];
            pblank <= lfsr[1];
            breq <= lfsr[2];
            repeat (6) begin
                @(negedge clk_i);
                nt += tick;
            end
            check({acp, blk}, {ppol, pblank});
        end
        check((nt - rises + r0) * (nt - rises + r0) <= 1, 1);
        $display("slave timing test done");
    endtask : slave_run
    task automatic results();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // watchdog: a hang counts as a mismatch
    initial begin
        #1000000;
        errors++;
        $display("[FAIL] %0d ns: run did not finish", $time);
        results();
    end
    initial begin
        {rstn_i, sel, breq, son, ppol, pblank} = 6'h00;
        en = 1'b1;
        errors = 0;
        comparisons = 0;
        repeat (8) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(negedge clk_i);
        check({mm, osc, pwr, poe, scan_oe, stat_oe}, 8'h00);
        for (int k = 0; k < 2; k++) begin
            set_mode(1'b1);
            master_run();
            if (k == 1) begin
                // reset in mid-run while mastering: everything drops, then the strap is seen again
                @(posedge clk_i);
                rstn_i <= 1'b0;
                @(negedge clk_i);
                check({mm, osc, pwr, poe, scan_oe, stat_oe, po, scan_o, stat_o, tick, acp, blk}, 16'h0000);
                repeat (2) @(posedge clk_i);
                rstn_i <= 1'b1;
                @(negedge clk_i);
                check({mm, osc, pwr, poe, scan_oe, stat_oe, po, scan_o, stat_o, tick, acp, blk}, 16'h0000);
                $display("reset test done");
            end
            set_mode(1'b0);
            slave_run();
        end
        results();
    end
endmodule : lcd_timing_select_test
